// [src/pst_pkg.sv]
// Shared constants for the telemetry readout block
`default_nettype none
package pst_pkg;
    // Command codes of the read-only result registers
    localparam logic [7:0] CMD_TEMP = 8'h2C;
    localparam logic [7:0] CMD_VIN = 8'h2E;
    localparam logic [7:0] CMD_I1 = 8'h30;
    localparam logic [7:0] CMD_I2 = 8'h34;
    localparam logic [7:0] CMD_I3 = 8'h38;
    localparam logic [7:0] CMD_I4 = 8'h3C;
    localparam int NUM_CH = 4;
    localparam int CODE_W = 14;
    localparam int TEMP_W = 8;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [13:0] RESET_CODE = 14'h0000;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] IDX_LO = 2'h0;
    localparam logic [1:0] IDX_HI = 2'h1;
    localparam logic [1:0] IDX_PAST = 2'h2;
    localparam logic ACK_LOW = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic PIN_RELEASE = 1'b1;
    // Scaling of the result codes (fixed by the converters, not by logic)
    localparam int TEMP_OFFSET_C = -20;
    localparam int TEMP_STEP_MILLIC = 652;
    localparam int VIN_STEP_UV = 3662;
    localparam int CUR_STEP_NA = 70190;
    localparam int CLASS_STEP_NA = 8950;
    // Refresh periods
    localparam int CLK_MHZ = 250;
    localparam int TEMP_PERIOD_MS = 1000;
    localparam int CUR_PERIOD_MS = 100;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int TEMP_PERIOD_CYC = CYC_PER_MS * TEMP_PERIOD_MS;
    localparam int CUR_PERIOD_CYC = CYC_PER_MS * CUR_PERIOD_MS;
    localparam logic [13:0] LIMIT2X_CODE = 14'h3FFF;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_TX, ST_MACK, ST_TXLOAD
    } pst_state_type;
endpackage
`default_nettype wire

// [src/pst_channel_current.sv]
// One channel's current result: periodic sampling, class hold, overcurrent
`default_nettype none
module pst_channel_current #(
    parameter int PERIOD = pst_pkg::CUR_PERIOD_CYC,
    parameter logic [13:0] LIMIT_CODE = pst_pkg::LIMIT2X_CODE
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic powered_in,
    input wire logic [13:0] adc_in,
    input wire logic class_done_in,
    input wire logic [13:0] class_in,
    output logic [13:0] result_out,
    output logic class_scale_out,
    output logic foldback_out,
    output logic disable_out
);
    logic [31:0] cnt_ff;
    logic pwr_q_ff;
    wire tick = powered_in && (cnt_ff == 32'(PERIOD - 1));
    wire over = adc_in >= LIMIT_CODE;
    // Turn-off or overcurrent disable wipes the result
    wire kill = (pwr_q_ff && !powered_in) || (foldback_out && !disable_out);
    wire [31:0] nxt_cnt = (!powered_in || tick) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_ff <= 32'h0000_0000;
            pwr_q_ff <= 1'b0;
        end else if (ce_in) begin
            cnt_ff <= nxt_cnt; // R6
            pwr_q_ff <= powered_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            result_out <= pst_pkg::RESET_CODE;
            class_scale_out <= 1'b0;
        end else if (ce_in) begin
            // A finishing classification beats a same-cycle wipe
            if (class_done_in) begin
                result_out <= class_in; // R9
                class_scale_out <= 1'b1; // R11
            end else if (kill) begin
                result_out <= pst_pkg::RESET_CODE; // R10
                class_scale_out <= 1'b0;
            end else if (tick) begin
                result_out <= adc_in; // R6 R10
                class_scale_out <= 1'b0; // R7
            end
        end
    end

    // Foldback first, disable one cycle later; both drop with port power
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            foldback_out <= 1'b0;
            disable_out <= 1'b0;
        end else if (ce_in) begin
            if (!powered_in) begin
                foldback_out <= 1'b0;
                disable_out <= 1'b0;
            end else begin
                foldback_out <= foldback_out || (tick && over); // R8
                disable_out <= disable_out || foldback_out; // R8
            end
        end
    end

    property p_class_load;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && class_done_in |=> result_out == $past(class_in) && class_scale_out;
    endproperty
    a_class_load: assert property (p_class_load) else $error("class result not loaded"); // R9

    property p_first_reading;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && tick && !kill && !class_done_in |=> !class_scale_out && result_out == $past(adc_in);
    endproperty
    a_first_reading: assert property (p_first_reading) else $error("reading not taken"); // R10

    property p_off_clears;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && pwr_q_ff && !powered_in && !class_done_in
        |=> result_out == pst_pkg::RESET_CODE && !class_scale_out;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("disable did not clear"); // R10

    property p_scale_hold;
        @(posedge clk_in) disable iff (reset_in)
        class_scale_out && ce_in && !tick && !kill |=> class_scale_out;
    endproperty
    a_scale_hold: assert property (p_scale_hold) else $error("class scale lost"); // R11

    property p_period;
        @(posedge clk_in) disable iff (reset_in)
        $changed(result_out) |-> $past(ce_in) && ($past(tick) || $past(kill) || $past(class_done_in));
    endproperty
    a_period: assert property (p_period) else $error("result changed off schedule"); // R6

    property p_fold;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && powered_in && tick && over ##1 (ce_in && powered_in) |-> foldback_out ##1 disable_out;
    endproperty
    a_fold: assert property (p_fold) else $error("overcurrent not folded and disabled"); // R8
endmodule
`default_nettype wire

// [src/pst_telemetry_readout.sv]
// Telemetry readout: I2C command slave with temperature, supply and current results
//
// How it works
// [R1] Temperature is an unsigned 8-bit code
// [R2] Temperature result refreshed once per second
// [R3] Supply voltage sent low byte, then high
// [R4] Supply voltage is a 14-bit code
// [R5] Channel currents at 30h, 34h, 38h, 3Ch
// [R6] Powered channel current refreshed every 100 ms
// [R7] Powered current code scaled 70.19 uA per count
// [R8] Overcurrent at or above doubled limit folds, then disables
// [R9] Finished classification loads class current
// [R10] Class value held until reading or disable
// [R11] Class reading flagged as finer scale, 8.95 uA per count
// [R12] Low-byte read latches the whole word
`default_nettype none
module pst_telemetry_readout #(
    parameter logic [6:0] DEV_ADDR = 7'h20, // Arbitrary value
    parameter int TEMP_PERIOD = pst_pkg::TEMP_PERIOD_CYC,
    parameter int CUR_PERIOD = pst_pkg::CUR_PERIOD_CYC,
    parameter logic [13:0] LIMIT_CODE = pst_pkg::LIMIT2X_CODE
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic [7:0] temp_adc_in,
    input wire logic [13:0] supply_adc_in,
    input wire logic supply_valid_in,
    input wire logic [3:0] port_powered_in,
    input wire logic [55:0] port_current_adc_in,
    input wire logic [3:0] class_done_in,
    input wire logic [55:0] class_current_in,
    output logic [3:0] class_scale_out,
    output logic [3:0] foldback_out,
    output logic [3:0] port_disable_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Result registers
    logic [7:0] die_temp_code_ff;
    logic [13:0] supply_voltage_code_ff;
    logic [31:0] tcnt_ff;
    logic [55:0] chan_result;
    wire temp_tick = tcnt_ff == 32'(TEMP_PERIOD - 1);
    wire [31:0] nxt_tcnt = temp_tick ? 32'h0000_0000 : tcnt_ff + 32'h0000_0001;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tcnt_ff <= 32'h0000_0000;
            die_temp_code_ff <= pst_pkg::RESET_BYTE;
            supply_voltage_code_ff <= pst_pkg::RESET_CODE;
        end else if (ce_in) begin
            tcnt_ff <= nxt_tcnt;
            if (temp_tick) begin
                die_temp_code_ff <= temp_adc_in; // R1 R2
            end
            if (supply_valid_in) begin
                supply_voltage_code_ff <= supply_adc_in; // R4
            end
        end
    end

    // Codes are raw counts; the step sizes live with the converters
    genvar gi;
    generate
        for (gi = 0; gi < pst_pkg::NUM_CH; gi++) begin : g_ch
            pst_channel_current #(.PERIOD(CUR_PERIOD), .LIMIT_CODE(LIMIT_CODE)) u_ch (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .ce_in(ce_in),
                .powered_in(port_powered_in[gi]),
                .adc_in(port_current_adc_in[gi*14 +: 14]),
                .class_done_in(class_done_in[gi]),
                .class_in(class_current_in[gi*14 +: 14]),
                .result_out(chan_result[gi*14 +: 14]),
                .class_scale_out(class_scale_out[gi]),
                .foldback_out(foldback_out[gi]),
                .disable_out(port_disable_out[gi])
            );
        end
    endgenerate

    // Unmapped command codes read as zero
    function automatic logic [15:0] reg_word(input logic [7:0] cmd, input logic [7:0] t,
                                             input logic [13:0] v, input logic [55:0] ch);
        case (cmd)
            pst_pkg::CMD_TEMP: reg_word = {8'h00, t};
            pst_pkg::CMD_VIN: reg_word = {2'b00, v};
            pst_pkg::CMD_I1: reg_word = {2'b00, ch[13:0]};
            pst_pkg::CMD_I2: reg_word = {2'b00, ch[27:14]};
            pst_pkg::CMD_I3: reg_word = {2'b00, ch[41:28]};
            pst_pkg::CMD_I4: reg_word = {2'b00, ch[55:42]};
            default: reg_word = pst_pkg::RESET_WORD;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // I2C slave
    pst_pkg::pst_state_type state_ff, after_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] sr_ff;
    logic [7:0] cmd_ff;
    logic [15:0] shadow_ff;
    logic [1:0] byte_idx_ff;
    logic ack_on_ff;
    logic scl_q_ff;
    logic sda_q_ff;
    wire scl_rise = scl_in && !scl_q_ff;
    wire scl_fall = !scl_in && scl_q_ff;
    wire bus_start = scl_in && scl_q_ff && sda_q_ff && !sda_in;
    wire bus_stop = scl_in && scl_q_ff && !sda_q_ff && sda_in;
    wire [7:0] rx_byte = {sr_ff[6:0], sda_in};
    wire last_bit = bit_cnt_ff == pst_pkg::BIT_LAST;
    wire [15:0] sel_word = reg_word(cmd_ff, die_temp_code_ff, supply_voltage_code_ff,
                                    chan_result);
    wire load_lo = state_ff == pst_pkg::ST_ACK && ack_on_ff && scl_fall
                   && after_ff == pst_pkg::ST_TX;
    wire [7:0] next_byte = (byte_idx_ff == pst_pkg::IDX_HI) ? shadow_ff[15:8]
                           : pst_pkg::RESET_BYTE;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            sda_out <= 1'b0;
        end else if (ce_in) begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= pst_pkg::ST_IDLE;
            after_ff <= pst_pkg::ST_IDLE;
            bit_cnt_ff <= 3'h0;
            sr_ff <= pst_pkg::RESET_BYTE;
            cmd_ff <= pst_pkg::RESET_BYTE;
            shadow_ff <= pst_pkg::RESET_WORD;
            byte_idx_ff <= pst_pkg::IDX_LO;
            ack_on_ff <= 1'b0;
            sda_oe_n_out <= pst_pkg::PIN_RELEASE;
        end else if (ce_in) begin
            if (bus_start || bus_stop) begin
                state_ff <= bus_start ? pst_pkg::ST_ADDR : pst_pkg::ST_IDLE;
                bit_cnt_ff <= 3'h0;
                ack_on_ff <= 1'b0;
                sda_oe_n_out <= pst_pkg::PIN_RELEASE;
            end else begin
                unique case (state_ff)
                    pst_pkg::ST_IDLE: begin
                    end
                    pst_pkg::ST_ADDR, pst_pkg::ST_CMD, pst_pkg::ST_WDATA: begin
                        if (scl_rise) begin
                            sr_ff <= rx_byte;
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                            if (last_bit) begin
                                state_ff <= pst_pkg::ST_ACK;
                                // Writes to these read-only results are acked and dropped
                                after_ff <= pst_pkg::ST_WDATA;
                                if (state_ff == pst_pkg::ST_ADDR) begin
                                    if (rx_byte[7:1] != DEV_ADDR) begin
                                        state_ff <= pst_pkg::ST_IDLE;
                                    end else if (rx_byte[0] == pst_pkg::RW_READ) begin
                                        after_ff <= pst_pkg::ST_TX;
                                    end else begin
                                        after_ff <= pst_pkg::ST_CMD;
                                    end
                                end else if (state_ff == pst_pkg::ST_CMD) begin
                                    cmd_ff <= rx_byte;
                                end
                            end
                        end
                    end
                    pst_pkg::ST_ACK: begin
                        if (scl_fall && !ack_on_ff) begin
                            ack_on_ff <= 1'b1;
                            sda_oe_n_out <= pst_pkg::ACK_LOW;
                        end else if (scl_fall) begin
                            ack_on_ff <= 1'b0;
                            bit_cnt_ff <= 3'h0;
                            state_ff <= after_ff;
                            if (load_lo) begin
                                shadow_ff <= sel_word; // R12
                                sr_ff <= sel_word[7:0]; // R3 R5
                                sda_oe_n_out <= sel_word[7];
                                byte_idx_ff <= pst_pkg::IDX_HI;
                            end else begin
                                sda_oe_n_out <= pst_pkg::PIN_RELEASE;
                            end
                        end
                    end
                    pst_pkg::ST_TX: begin
                        if (scl_fall && last_bit) begin
                            sda_oe_n_out <= pst_pkg::PIN_RELEASE;
                            state_ff <= pst_pkg::ST_MACK;
                        end else if (scl_fall) begin
                            sr_ff <= {sr_ff[6:0], 1'b0};
                            sda_oe_n_out <= sr_ff[6];
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        end
                    end
                    pst_pkg::ST_MACK: begin
                        if (scl_rise && sda_in == pst_pkg::ACK_LOW) begin
                            sr_ff <= next_byte; // R3 R12
                            byte_idx_ff <= pst_pkg::IDX_PAST;
                            state_ff <= pst_pkg::ST_TXLOAD;
                        end else if (scl_rise) begin
                            state_ff <= pst_pkg::ST_IDLE;
                        end
                    end
                    pst_pkg::ST_TXLOAD: begin
                        if (scl_fall) begin
                            sda_oe_n_out <= sr_ff[7];
                            bit_cnt_ff <= 3'h0;
                            state_ff <= pst_pkg::ST_TX;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_temp_refresh;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && temp_tick |=> die_temp_code_ff == $past(temp_adc_in);
    endproperty
    a_temp_refresh: assert property (p_temp_refresh) else $error("temperature not refreshed"); // R2

    property p_temp_hold;
        @(posedge clk_in) disable iff (reset_in)
        !(ce_in && temp_tick) |=> $stable(die_temp_code_ff);
    endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("temperature changed early"); // R2

    property p_temp_read;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && load_lo && !bus_start && !bus_stop && cmd_ff == pst_pkg::CMD_TEMP
        |=> sr_ff == $past(die_temp_code_ff) && shadow_ff[15:8] == pst_pkg::RESET_BYTE;
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature byte wrong"); // R1

    property p_vin_lo_first;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && load_lo && !bus_start && !bus_stop && cmd_ff == pst_pkg::CMD_VIN
        |=> sr_ff == $past(supply_voltage_code_ff[7:0]) && shadow_ff[15:14] == 2'b00;
    endproperty
    a_vin_lo_first: assert property (p_vin_lo_first) else $error("supply low byte wrong"); // R3

    property p_vin_capture;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && supply_valid_in |=> supply_voltage_code_ff == $past(supply_adc_in);
    endproperty
    a_vin_capture: assert property (p_vin_capture) else $error("supply code not taken"); // R4

    property p_ch_map;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && load_lo && !bus_start && !bus_stop && cmd_ff == pst_pkg::CMD_I3
        |=> sr_ff == $past(chan_result[35:28]);
    endproperty
    a_ch_map: assert property (p_ch_map) else $error("channel map wrong"); // R5

    property p_hi_latched;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && state_ff == pst_pkg::ST_MACK && scl_rise && !sda_in
        && byte_idx_ff == pst_pkg::IDX_HI && !bus_start && !bus_stop
        |=> sr_ff == $past(shadow_ff[15:8]) ##1 $stable(shadow_ff);
    endproperty
    a_hi_latched: assert property (p_hi_latched) else $error("high byte not latched"); // R12

    property p_ack_drive;
        @(posedge clk_in) disable iff (reset_in)
        ce_in && state_ff == pst_pkg::ST_ACK && !ack_on_ff && scl_fall && !bus_start && !bus_stop
        |=> sda_oe_n_out == pst_pkg::ACK_LOW;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven"); // R3
endmodule
`default_nettype wire

// [verification/pst_host_model.sv]
// Host-side I2C master model for the telemetry readout command port
`default_nettype none
module pst_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h20
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;
    event lo_done;
    logic ack_ok;
    logic a;
    // SCL idles high between frames; SDA only ever pulled low or released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        ack_ok = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Four-clock phases keep SCL well over the three-clock minimum each way
    task automatic put_bit(input logic b);
        sda_out = b;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
        tick(2);
    endtask
    task automatic get_bit(output logic b);
        sda_out = 1'b1;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        b = sda_in;
        scl_out = 1'b0;
        tick(2);
    endtask
    // Also serves as repeated start, since SCL is low when it is entered mid-frame
    task automatic start();
        sda_out = 1'b1;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_out = 1'b0;
        tick(4);
        scl_out = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_out = 1'b0;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_out = 1'b1;
        tick(4);
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(a);
        if (a !== 1'b0) begin
            ack_ok = 1'b0;
        end
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            get_bit(v[i]);
        end
        put_bit(last);
    endtask
    task automatic read_reg(input logic [7:0] cmd, output logic [15:0] w);
        ack_ok = 1'b1;
        start();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(cmd);
        start();
        send_byte({DEV_ADDR, 1'b1});
        recv_byte(1'b0, w[7:0]);
        ->lo_done;
        recv_byte(1'b1, w[15:8]);
        stop();
    endtask
endmodule
`default_nettype wire

// [verification/pst_telemetry_readout_tb_top.sv]
// Self-checking bench for the telemetry readout block
`default_nettype none
module pst_telemetry_readout_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TP = 2000;
    localparam int CP = 1000;
    localparam logic [13:0] LIM = 14'h3000;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce_in = 1'b1;
    logic [7:0] temp_adc_in = 8'h00;
    logic [13:0] supply_adc_in = 14'h0000;
    logic supply_valid_in = 1'b0;
    logic [3:0] port_powered_in = 4'h0;
    logic [55:0] cur_adc = 56'h0;
    logic [3:0] class_done_in = 4'h0;
    logic [55:0] class_cur = 56'h0;
    logic scl;
    logic sda_m;
    logic sda_d;
    logic sda_oe_n;
    logic [3:0] cls;
    logic [3:0] fold;
    logic [3:0] dis;
    logic [15:0] w;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // Pull-up: the line is low only when some party pulls it
    wire sda_bus = sda_m & (sda_oe_n | sda_d);
    always #2 clk_in = ~clk_in;
    pst_telemetry_readout #(.TEMP_PERIOD(TP), .CUR_PERIOD(CP), .LIMIT_CODE(LIM)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .scl_in(scl),
        .sda_in(sda_bus), .sda_out(sda_d), .sda_oe_n_out(sda_oe_n),
        .temp_adc_in(temp_adc_in), .supply_adc_in(supply_adc_in),
        .supply_valid_in(supply_valid_in), .port_powered_in(port_powered_in),
        .port_current_adc_in(cur_adc), .class_done_in(class_done_in),
        .class_current_in(class_cur), .class_scale_out(cls), .foldback_out(fold),
        .port_disable_out(dis));
    pst_host_model #(.DEV_ADDR(7'h20)) host (
        .clk_in(clk_in), .sda_in(sda_bus), .scl_out(scl), .sda_out(sda_m));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        host.read_reg(cmd, w);
        check($sformatf("read %h", cmd), w, exp);
        check("ack", {15'h0000, host.ack_ok}, 16'h0001);
    endtask
    task automatic strobe();
        supply_valid_in = 1'b1;
        tick(1);
        supply_valid_in = 1'b0;
    endtask
    task automatic test_done();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        // Last entry is an unmapped command, which reads as zero bytes
        logic [7:0] cmds [7] = '{8'h2C, 8'h2E, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h2D};
        foreach (cmds[i]) begin
            rd(cmds[i], 16'h0000);
        end
        check("flags", {4'h0, cls, fold, dis}, 16'h0000);
        check("sda value", {15'h0000, sda_d}, 16'h0000);
    endtask
    task automatic t_refuse();
        host.ack_ok = 1'b1;
        host.start();
        host.send_byte({7'h21, 1'b1});
        host.stop();
        check("foreign address ack", {15'h0000, host.ack_ok}, 16'h0000);
        host.ack_ok = 1'b1;
        host.start();
        host.send_byte({7'h20, 1'b0});
        host.send_byte(pst_pkg::CMD_VIN);
        host.send_byte(8'h55);
        host.stop();
        check("write ack", {15'h0000, host.ack_ok}, 16'h0001);
        rd(pst_pkg::CMD_VIN, 16'h3FFF);
    endtask
    task automatic t_temp();
        temp_adc_in = 8'hA5;
        tick(TP + 10);
        rd(pst_pkg::CMD_TEMP, 16'h00A5);
        temp_adc_in = 8'h3C;
        tick(TP + 10);
        rd(pst_pkg::CMD_TEMP, 16'h003C);
    endtask
    task automatic t_supply();
        supply_adc_in = 14'h2A5C;
        strobe();
        fork
            host.read_reg(pst_pkg::CMD_VIN, w);
            begin
                @(host.lo_done);
                supply_adc_in = 14'h3FFF;
                strobe();
            end
        join
        check("latched word", w, 16'h2A5C);
        rd(pst_pkg::CMD_VIN, 16'h3FFF);
    endtask
    task automatic t_current();
        cur_adc = {14'h0ABC, 14'h1234, 14'h0F0F, 14'h2DEF};
        port_powered_in = 4'hF;
        tick(CP + 20);
        for (int i = 0; i < 4; i++) begin
            rd(8'h30 + 8'(4 * i), {2'b00, cur_adc[14 * i +: 14]});
        end
        check("class flag", {12'h000, cls}, 16'h0000);
        cur_adc[13:0] = 14'h0777;
        tick(CP + 20);
        rd(pst_pkg::CMD_I1, 16'h0777);
    endtask
    task automatic t_class();
        port_powered_in = 4'h0;
        tick(3);
        rd(pst_pkg::CMD_I1, 16'h0000);
        class_cur[27:0] = {14'h0321, 14'h0567};
        class_done_in = 4'h3;
        tick(1);
        class_done_in = 4'h0;
        tick(2);
        check("class flag", {12'h000, cls}, 16'h0003);
        rd(pst_pkg::CMD_I1, 16'h0567);
        port_powered_in = 4'h1;
        tick(2);
        rd(pst_pkg::CMD_I1, 16'h0567);
        check("class flag", {12'h000, cls}, 16'h0003);
        tick(CP);
        rd(pst_pkg::CMD_I1, 16'h0777);
        check("class flag", {12'h000, cls}, 16'h0002);
        port_powered_in = 4'h3;
        tick(2);
        port_powered_in = 4'h1;
        tick(3);
        check("class flag", {12'h000, cls}, 16'h0000);
        rd(pst_pkg::CMD_I2, 16'h0000);
        ce_in = 1'b0;
        class_done_in = 4'h4;
        tick(2);
        class_done_in = 4'h0;
        ce_in = 1'b1;
        tick(2);
        check("frozen class flag", {12'h000, cls}, 16'h0000);
    endtask
    task automatic t_limit();
        cur_adc[55:42] = LIM;
        port_powered_in = 4'h8;
        for (int k = 0; k < CP + 20 && fold[3] !== 1'b1; k++) begin
            tick(1);
        end
        check("foldback", {12'h000, fold}, 16'h0008);
        check("disable", {12'h000, dis}, 16'h0000);
        tick(1);
        check("disable", {12'h000, dis}, 16'h0008);
        rd(pst_pkg::CMD_I4, 16'h0000);
        port_powered_in = 4'h0;
        tick(3);
        check("released", {8'h00, fold, dis}, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        tick(3);
        reset_in = 1'b0;
        tick(3);
        t_reset();
        t_temp();
        t_supply();
        t_refuse();
        t_current();
        t_class();
        t_limit();
        test_done();
    end
endmodule
`default_nettype wire
